// ==== core/fscr_core.sv ====
// Operation
// - progress flag is 1 while program, erase or status write runs
// - while busy only status reads and suspend are obeyed
// - progress flag drops to 0 when the operation finishes
// - write enable sets the write enable latch
// - latch clears at reset, write disable, program, erase, status write
// - three block protect bits, writable, zero after reset
// - top_bottom_select 0 protects from top, 1 from bottom
// - small_granule_select picks 4KB sectors, else 64KB blocks
// - complement_protect inverts the protected region
// - guard and lockdown 0: write pin ignored, latch enables writes
// - guard 1, pin low: status writes refused
// - guard 1, pin high: status writes allowed with latch set
// - write pin gates status writes only outside quad mode
// - lockdown 1 refuses status writes until reset
// - AAh then 55h prefix sets a second lockdown bit, also cleared at reset
// - suspend 75h sets paused flag, resume 7Ah or reset clears
// - three security lock bits, set only, lock their register
// - quad_enable selects quad pin use, hold otherwise
// - scheme select 1 uses individual locks, all set at reset
// - two drive bits choose 100, 75, 50, 25 percent, default 25
// - reserved bits read zero, writes to them do nothing
// - program or erase touching protected space is ignored
`timescale 1ns/1ps
`default_nettype none
module fscr_core #(
  parameter int SR_WRITE_CYCLES = fscr_pkg::SR_WRITE_CYCLES_DEF
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_mosi_i,
  input wire logic wp_n_i,
  input wire logic op_done_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  output logic busy_o,
  output logic op_start_o,
  output logic [7:0] op_code_o,
  output logic [fscr_pkg::ADDR_W-1:0] op_addr_o,
  output logic op_suspend_o,
  output logic op_resume_o,
  output logic quad_enable_o,
  output logic [1:0] output_strength_o
);
  localparam int TW = $clog2(SR_WRITE_CYCLES + 1);
  localparam logic [TW-1:0] TMR_LOAD = TW'(SR_WRITE_CYCLES);

  // refuse a status write time shorter than one core clock
  if (SR_WRITE_CYCLES < 1) begin : g_chk
    $error("SR_WRITE_CYCLES must be at least 1");
  end

  logic cs_s1, cs_s2, cs_s3, sclk_s1, sclk_s2, sclk_s3, mosi_s1, mosi_s2, wp_s1, wp_s2;
  logic sclk_rise, sclk_fall, cs_rise, in_frame;
  logic [2:0] bit_cnt_q, byte_cnt_q;
  logic [6:0] shift_q;
  logic [7:0] byte_in, cmd_q, wdata_q, tx_q;
  logic [fscr_pkg::ADDR_W-1:0] addr_q;
  fscr_pkg::fscr_phase_t phase_q;
  logic busy_q, wel_q, sus_q, srp_q, srl_q, otp_q, tb_q, sec_q, cmp_q, qe_q, wps_q;
  logic [2:0] bp_q, lb_q;
  logic [1:0] drv_q, pfx_q;
  logic [TW-1:0] tmr_q;
  logic cmd_ok, one_byte, ex_wren, ex_wrdi, ex_sus, ex_res, wr_go, wr_allowed;
  logic is_arr, is_sec, len_ok, hit, ex_arr;
  logic [4:0] clog;

  function automatic logic is_read(input logic [7:0] c);
    return c == fscr_pkg::OP_RD_STAT1 || c == fscr_pkg::OP_RD_STAT2 ||
           c == fscr_pkg::OP_RD_STAT3;
  endfunction

  function automatic logic needs_addr(input logic [7:0] c);
    return c == fscr_pkg::OP_PAGE_PROG || c == fscr_pkg::OP_QUAD_PROG ||
           c == fscr_pkg::OP_ERASE_4K || c == fscr_pkg::OP_ERASE_32K ||
           c == fscr_pkg::OP_ERASE_64K || c == fscr_pkg::OP_SECREG_ERASE ||
           c == fscr_pkg::OP_SECREG_PROG;
  endfunction

  // live status bytes, reserved bits read zero
  function automatic logic [7:0] status_byte(input logic [7:0] c);
    logic [7:0] v;
    v = 8'h00;
    if (c == fscr_pkg::OP_RD_STAT1) begin
      v[fscr_pkg::S1_BUSY] = busy_q;
      v[fscr_pkg::S1_WE_LATCH] = wel_q;
      v[fscr_pkg::S1_BP_LO +: 3] = bp_q;
      v[fscr_pkg::S1_TOP_BOT] = tb_q;
      v[fscr_pkg::S1_SMALL] = sec_q;
      v[fscr_pkg::S1_GUARD] = srp_q;
    end else if (c == fscr_pkg::OP_RD_STAT2) begin
      v[fscr_pkg::S2_LOCKDOWN] = srl_q | otp_q;
      v[fscr_pkg::S2_QUAD] = qe_q;
      v[fscr_pkg::S2_SECLOCK_LO +: 3] = lb_q;
      v[fscr_pkg::S2_COMPL] = cmp_q;
      v[fscr_pkg::S2_PAUSED] = sus_q;
    end else begin
      v[fscr_pkg::S3_SCHEME] = wps_q;
      v[fscr_pkg::S3_DRIVE_LO +: 2] = drv_q;
    end
    return v;
  endfunction

  // protection test of an aligned 2^clog range at address a
  function automatic logic prot_hit(input logic [fscr_pkg::ADDR_W-1:0] a,
                                    input logic [4:0] cl);
    logic [4:0] r;
    logic [4:0] m;
    logic ov;
    logic inr;
    r = 5'h00;
    if (bp_q == 3'h7) begin
      r = fscr_pkg::LOG_ARRAY;
    end else if (sec_q) begin
      r = (bp_q >= 3'h4) ? fscr_pkg::LOG_BLK32 :
          5'(fscr_pkg::LOG_SECTOR + {2'h0, bp_q} - 5'h01);
    end else if (bp_q != 3'h0) begin
      r = 5'(fscr_pkg::LOG_BLK64 + {2'h0, bp_q});
    end
    m = (cl > r) ? cl : r;
    ov = 1'b1;
    inr = (cl <= r);
    for (int i = 0; i < fscr_pkg::ADDR_W; i++) begin
      if (5'(i) >= m && a[i] == tb_q) ov = 1'b0;
      if (5'(i) >= r && a[i] == tb_q) inr = 1'b0;
    end
    // individual locks all set after reset and never released here
    if (wps_q) return 1'b1;
    if (cmp_q) return !(bp_q != 3'h0 && inr);
    return bp_q != 3'h0 && ov;
  endfunction

  // two-flop synchronisers plus an edge-detect stage
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {cs_s1, cs_s2, cs_s3} <= 3'h7;
      {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
      {mosi_s1, mosi_s2, wp_s1, wp_s2} <= 4'h0;
    end else begin
      {cs_s1, cs_s2, cs_s3} <= {spi_cs_n_i, cs_s1, cs_s2};
      {sclk_s1, sclk_s2, sclk_s3} <= {spi_sclk_i, sclk_s1, sclk_s2};
      {mosi_s1, mosi_s2, wp_s1, wp_s2} <= {spi_mosi_i, mosi_s1, wp_n_i, wp_s1};
    end
  end

  assign sclk_rise = sclk_s2 & ~sclk_s3;
  assign sclk_fall = ~sclk_s2 & sclk_s3;
  assign cs_rise = cs_s2 & ~cs_s3;
  assign in_frame = ~cs_s2;
  assign byte_in = {shift_q, mosi_s2};

  // frame receiver: command, address and data bytes
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_cnt_q <= 3'h0;
      byte_cnt_q <= 3'h0;
      shift_q <= 7'h00;
      cmd_q <= 8'h00;
      wdata_q <= 8'h00;
      addr_q <= '0;
      phase_q <= fscr_pkg::ST_CMD;
    end else if (!in_frame) begin
      bit_cnt_q <= 3'h0;
      byte_cnt_q <= 3'h0;
      phase_q <= fscr_pkg::ST_CMD;
    end else if (sclk_rise) begin
      shift_q <= byte_in[6:0];
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (bit_cnt_q == 3'h7) begin
        if (byte_cnt_q != 3'h7) byte_cnt_q <= byte_cnt_q + 3'h1;
        case (phase_q)
          fscr_pkg::ST_CMD: begin
            cmd_q <= byte_in;
            phase_q <= is_read(byte_in) ? fscr_pkg::ST_READ :
                       needs_addr(byte_in) ? fscr_pkg::ST_ADDR : fscr_pkg::ST_DATA;
          end
          fscr_pkg::ST_ADDR: begin
            addr_q <= {addr_q[fscr_pkg::ADDR_W-9:0], byte_in};
            if (byte_cnt_q == 3'h3) phase_q <= fscr_pkg::ST_DATA;
          end
          fscr_pkg::ST_DATA: begin
            if (byte_cnt_q == 3'h1) wdata_q <= byte_in;
          end
          default: ;
        endcase
      end
    end
  end

  // status read shifter, reloaded each byte so the flags stay live
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_q <= 8'h00;
      spi_miso_o <= 1'b0;
      spi_miso_oe_o <= 1'b0;
    end else if (!in_frame) begin
      spi_miso_oe_o <= 1'b0;
    end else if (sclk_rise && bit_cnt_q == 3'h7 &&
                 (phase_q == fscr_pkg::ST_READ ||
                  (phase_q == fscr_pkg::ST_CMD && is_read(byte_in)))) begin
      tx_q <= status_byte(phase_q == fscr_pkg::ST_CMD ? byte_in : cmd_q);
    end else if (sclk_fall && phase_q == fscr_pkg::ST_READ) begin
      spi_miso_o <= tx_q[7];
      tx_q <= {tx_q[6:0], 1'b0};
      spi_miso_oe_o <= 1'b1;
    end
  end

  // instruction decode at the end of a whole-byte frame
  always_comb begin
    cmd_ok = cs_rise && bit_cnt_q == 3'h0 &&
             (!busy_q || is_read(cmd_q) || cmd_q == fscr_pkg::OP_SUSPEND);
    one_byte = cmd_ok && byte_cnt_q == 3'h1;
    ex_wren = one_byte && cmd_q == fscr_pkg::OP_WR_ENABLE;
    ex_wrdi = one_byte && cmd_q == fscr_pkg::OP_WR_DISABLE;
    ex_sus = one_byte && cmd_q == fscr_pkg::OP_SUSPEND && busy_q && tmr_q == '0 && !sus_q;
    ex_res = one_byte && cmd_q == fscr_pkg::OP_RESUME && sus_q;
    wr_allowed = wel_q && !srl_q && !otp_q && !(srp_q && !wp_s2 && !qe_q);
    wr_go = cmd_ok && byte_cnt_q == 3'h2 && wr_allowed &&
            (cmd_q == fscr_pkg::OP_WR_STAT1 || cmd_q == fscr_pkg::OP_WR_STAT2 ||
             cmd_q == fscr_pkg::OP_WR_STAT3);
    is_sec = cmd_q == fscr_pkg::OP_SECREG_ERASE || cmd_q == fscr_pkg::OP_SECREG_PROG;
    is_arr = 1'b1;
    len_ok = byte_cnt_q == 3'h4;
    clog = fscr_pkg::LOG_ARRAY;
    case (cmd_q)
      fscr_pkg::OP_PAGE_PROG, fscr_pkg::OP_QUAD_PROG: begin
        clog = fscr_pkg::LOG_PAGE;
        len_ok = byte_cnt_q >= 3'h5;
      end
      fscr_pkg::OP_SECREG_PROG: len_ok = byte_cnt_q >= 3'h5;
      fscr_pkg::OP_ERASE_4K: clog = fscr_pkg::LOG_SECTOR;
      fscr_pkg::OP_ERASE_32K: clog = fscr_pkg::LOG_BLK32;
      fscr_pkg::OP_ERASE_64K: clog = fscr_pkg::LOG_BLK64;
      fscr_pkg::OP_ERASE_ALL_A, fscr_pkg::OP_ERASE_ALL_B: len_ok = byte_cnt_q == 3'h1;
      fscr_pkg::OP_SECREG_ERASE: ;
      default: is_arr = 1'b0;
    endcase
    hit = is_sec ? (addr_q[13:12] == 2'h0 || lb_q[addr_q[13:12] - 2'h1]) :
          prot_hit(addr_q, clog);
    ex_arr = cmd_ok && is_arr && len_ok && wel_q && !sus_q && !hit;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) wel_q <= 1'b0;
    else if (ex_wren) wel_q <= 1'b1;
    else if (ex_wrdi || wr_go || ex_arr) wel_q <= 1'b0;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q <= 1'b0;
      tmr_q <= '0;
    end else begin
      if (wr_go) tmr_q <= TMR_LOAD;
      else if (tmr_q != '0) tmr_q <= tmr_q - TW'(1);
      if (ex_arr || wr_go || ex_res) busy_q <= 1'b1;
      else if (ex_sus || tmr_q == TW'(1) || (op_done_i && tmr_q == '0)) busy_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) sus_q <= 1'b0;
    else if (ex_sus) sus_q <= 1'b1;
    else if (ex_res) sus_q <= 1'b0;
  end

  // prefix tracker, only consecutive AAh, 55h frames count
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) pfx_q <= 2'h0;
    else if (cs_rise) begin
      if (one_byte && cmd_q == fscr_pkg::OP_PREFIX_A) pfx_q <= 2'h1;
      else if (one_byte && cmd_q == fscr_pkg::OP_PREFIX_B && pfx_q == 2'h1) pfx_q <= 2'h2;
      else pfx_q <= 2'h0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {srp_q, sec_q, tb_q, srl_q, otp_q, cmp_q, qe_q, wps_q} <= 8'h00;
      bp_q <= fscr_pkg::BP_RST;
      lb_q <= fscr_pkg::SECLOCK_RST;
      drv_q <= fscr_pkg::DRIVE_RST;
    end else if (wr_go) begin
      case (cmd_q)
        fscr_pkg::OP_WR_STAT1: begin
          bp_q <= wdata_q[fscr_pkg::S1_BP_LO +: 3];
          tb_q <= wdata_q[fscr_pkg::S1_TOP_BOT];
          sec_q <= wdata_q[fscr_pkg::S1_SMALL];
          srp_q <= wdata_q[fscr_pkg::S1_GUARD];
        end
        fscr_pkg::OP_WR_STAT2: begin
          srl_q <= wdata_q[fscr_pkg::S2_LOCKDOWN];
          otp_q <= wdata_q[fscr_pkg::S2_LOCKDOWN] && pfx_q == 2'h2;
          qe_q <= wdata_q[fscr_pkg::S2_QUAD];
          lb_q <= lb_q | wdata_q[fscr_pkg::S2_SECLOCK_LO +: 3];
          cmp_q <= wdata_q[fscr_pkg::S2_COMPL];
        end
        default: begin
          wps_q <= wdata_q[fscr_pkg::S3_SCHEME];
          drv_q <= wdata_q[fscr_pkg::S3_DRIVE_LO +: 2];
        end
      endcase
    end
  end

  // array engine handshake and configuration outputs
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {op_start_o, op_suspend_o, op_resume_o, quad_enable_o} <= 4'h0;
      op_code_o <= 8'h00;
      op_addr_o <= '0;
      output_strength_o <= fscr_pkg::DRIVE_RST;
    end else begin
      op_start_o <= ex_arr;
      op_suspend_o <= ex_sus;
      op_resume_o <= ex_res;
      quad_enable_o <= qe_q;
      output_strength_o <= drv_q;
      if (ex_arr) begin
        op_code_o <= cmd_q;
        op_addr_o <= addr_q;
      end
    end
  end

  assign busy_o = busy_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_busy_start; ex_arr |=> busy_o && op_start_o; endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not raised");
  property p_busy_ignore; busy_q && cs_rise && cmd_q == fscr_pkg::OP_WR_ENABLE |=> $stable(wel_q); endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("command taken while busy");
  property p_busy_done; wr_go |-> ##[1:300] !busy_q; endproperty
  a_busy_done: assert property (p_busy_done) else $error("status write never ends");
  property p_wel_set; ex_wren |=> wel_q; endproperty
  a_wel_set: assert property (p_wel_set) else $error("latch not set");
  property p_wel_clr; op_start_o |-> !wel_q; endproperty
  a_wel_clr: assert property (p_wel_clr) else $error("latch kept after start");
  property p_wp_block; cs_rise && srp_q && !wp_s2 && !qe_q |-> !wr_go; endproperty
  a_wp_block: assert property (p_wp_block) else $error("write pin ignored");
  property p_lockdown; srl_q |=> $stable(bp_q) && $stable(qe_q) && srl_q; endproperty
  a_lockdown: assert property (p_lockdown) else $error("status changed under lockdown");
  property p_otp; otp_q |=> otp_q; endproperty
  a_otp: assert property (p_otp) else $error("permanent lock lost");
  property p_sus; ex_sus |=> sus_q && !busy_q ##1 op_suspend_o == 1'b0; endproperty
  a_sus: assert property (p_sus) else $error("pause flag wrong");
  property p_lb; ($past(lb_q) & ~lb_q) == 3'h0; endproperty
  a_lb: assert property (p_lb) else $error("security lock cleared");
  property p_prot; cmd_ok && hit |=> !op_start_o; endproperty
  a_prot: assert property (p_prot) else $error("protected target started");

  c_status_write: cover property (wr_go ##[1:300] !busy_q);
  c_prot_drop: cover property (cmd_ok && is_arr && hit);
  c_suspend_resume: cover property (ex_sus ##[1:1000] ex_res);
  c_read: cover property (spi_miso_oe_o && busy_o);
endmodule
`default_nettype wire

// ==== pkg/fscr_pkg.sv ====
`default_nettype none
package fscr_pkg;
  // instruction codes
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_RD_STAT1 = 8'h05;
  localparam logic [7:0] OP_RD_STAT2 = 8'h35;
  localparam logic [7:0] OP_RD_STAT3 = 8'h15;
  localparam logic [7:0] OP_WR_STAT1 = 8'h01;
  localparam logic [7:0] OP_WR_STAT2 = 8'h31;
  localparam logic [7:0] OP_WR_STAT3 = 8'h11;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG = 8'h32;
  localparam logic [7:0] OP_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_ERASE_32K = 8'h52;
  localparam logic [7:0] OP_ERASE_64K = 8'hD8;
  localparam logic [7:0] OP_ERASE_ALL_A = 8'hC7;
  localparam logic [7:0] OP_ERASE_ALL_B = 8'h60;
  localparam logic [7:0] OP_SECREG_ERASE = 8'h44;
  localparam logic [7:0] OP_SECREG_PROG = 8'h42;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_PREFIX_A = 8'hAA;
  localparam logic [7:0] OP_PREFIX_B = 8'h55;
  // status byte one field positions
  localparam int S1_BUSY = 0;
  localparam int S1_WE_LATCH = 1;
  localparam int S1_BP_LO = 2;
  localparam int S1_TOP_BOT = 5;
  localparam int S1_SMALL = 6;
  localparam int S1_GUARD = 7;
  // status byte two field positions
  localparam int S2_LOCKDOWN = 0;
  localparam int S2_QUAD = 1;
  localparam int S2_SECLOCK_LO = 3;
  localparam int S2_COMPL = 6;
  localparam int S2_PAUSED = 7;
  // status byte three field positions
  localparam int S3_SCHEME = 2;
  localparam int S3_DRIVE_LO = 5;
  // reset values
  localparam logic [2:0] BP_RST = 3'h0;
  localparam logic [2:0] SECLOCK_RST = 3'h0;
  localparam logic [1:0] DRIVE_RST = 2'h3;
  // array geometry as log2 of byte counts
  localparam int ADDR_W = 23;
  localparam logic [4:0] LOG_PAGE = 5'h08;
  localparam logic [4:0] LOG_SECTOR = 5'h0C;
  localparam logic [4:0] LOG_BLK32 = 5'h0F;
  localparam logic [4:0] LOG_BLK64 = 5'h10;
  localparam logic [4:0] LOG_ARRAY = 5'h17;
  // status write duration in core clocks
  localparam int SR_WRITE_CYCLES_DEF = 16;
  typedef enum logic [1:0] {ST_CMD, ST_ADDR, ST_DATA, ST_READ} fscr_phase_t;
endpackage
`default_nettype wire

// ==== test/fscr_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module fscr_host (
  input wire logic clk_i,
  input wire logic miso_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic mosi_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o
);
  // half a 200 ns link period in 25 ns core clocks
  localparam int HALF = 4;

  // idle bus: select high, clock parked low (mode 0)
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
  end

  // one frame, bytes msb first; miso taken late in the high phase, before the fall
  task automatic frame(input int nbytes, input logic [39:0] tx, input logic want_rx);
    logic [7:0] rx;
    rx = 8'h00;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (int i = 8 * nbytes - 1; i >= 0; i--) begin
      mosi_o <= tx[i];
      repeat (HALF) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (HALF) @(posedge clk_i);
      rx = {rx[6:0], miso_i};
      sclk_o <= 1'b0;
    end
    repeat (HALF) @(posedge clk_i);
    cs_n_o <= 1'b1;
    // released data line shows the inverse of its last bit
    mosi_o <= ~mosi_o;
    rx_valid_o <= want_rx;
    rx_data_o <= rx;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    repeat (2 * HALF) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ==== test/flash_status_config_registers_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module flash_status_config_registers_test;
  localparam logic [7:0] RD1 = fscr_pkg::OP_RD_STAT1;
  localparam logic [7:0] RD2 = fscr_pkg::OP_RD_STAT2;
  localparam logic [7:0] RD3 = fscr_pkg::OP_RD_STAT3;
  localparam logic [7:0] WR1 = fscr_pkg::OP_WR_STAT1;
  localparam logic [7:0] WR2 = fscr_pkg::OP_WR_STAT2;
  localparam logic [7:0] WR3 = fscr_pkg::OP_WR_STAT3;
  localparam logic [7:0] WREN = fscr_pkg::OP_WR_ENABLE;
  localparam logic [7:0] WRDI = fscr_pkg::OP_WR_DISABLE;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp_n = 1'b1;
  logic op_done = 1'b0;
  logic cs_n, sclk, mosi, miso, miso_oe, busy, op_start, op_suspend, op_resume, quad_en;
  logic rx_valid;
  logic oe_seen = 1'b0;
  logic [7:0] rx_data;
  logic [7:0] op_code;
  logic [fscr_pkg::ADDR_W-1:0] op_addr;
  logic [1:0] strength;
  logic [31:0] exp_q[$];
  logic [31:0] got;
  logic [31:0] rnd_q = 32'h0000_0026;
  logic [48:0] ent;
  logic [7:0] d;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  // protection cases: status 1, 2, 3, erase address, accepted
  logic [48:0] tbl [10] = '{
    {8'h04, 8'h00, 8'h60, 24'h7FF000, 1'b0},
    {8'h04, 8'h00, 8'h60, 24'h7E0000, 1'b0},
    {8'h04, 8'h00, 8'h60, 24'h000000, 1'b1},
    {8'h24, 8'h00, 8'h60, 24'h000000, 1'b0},
    {8'h24, 8'h00, 8'h60, 24'h7FF000, 1'b1},
    {8'h44, 8'h00, 8'h60, 24'h7FE000, 1'b1},
    {8'h04, 8'h00, 8'h60, 24'h7FE000, 1'b0},
    {8'h24, 8'h40, 8'h60, 24'h000000, 1'b1},
    {8'h24, 8'h40, 8'h60, 24'h020000, 1'b0},
    {8'h00, 8'h00, 8'h64, 24'h000000, 1'b0}};

  always #12.5 clk = ~clk;

  fscr_core #(.SR_WRITE_CYCLES(2)) dut_u (
    .core_clk_i(clk), .rst_n_i(rst_n), .spi_cs_n_i(cs_n), .spi_sclk_i(sclk),
    .spi_mosi_i(mosi), .wp_n_i(wp_n), .op_done_i(op_done), .spi_miso_o(miso),
    .spi_miso_oe_o(miso_oe), .busy_o(busy), .op_start_o(op_start), .op_code_o(op_code),
    .op_addr_o(op_addr), .op_suspend_o(op_suspend), .op_resume_o(op_resume),
    .quad_enable_o(quad_en), .output_strength_o(strength));

  fscr_host host_u (
    .clk_i(clk), .miso_i(miso), .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi),
    .rx_valid_o(rx_valid), .rx_data_o(rx_data));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  task automatic end_sim();
    if (fail_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmd(input int n, input logic [39:0] tx);
    host_u.frame(n, tx, 1'b0);
  endtask

  task automatic rd(input logic [7:0] op, input logic [7:0] e);
    oe_seen = 1'b0;
    exp_q.push_back({24'h0, e});
    host_u.frame(2, {16'h0, op, 8'h00}, 1'b1);
    chk({31'h0, oe_seen}, 32'h1);
    chk({31'h0, miso_oe}, 32'h0);
  endtask

  // notes that the read data line was driven during a frame
  always @(posedge clk) begin
    if (miso_oe === 1'b1) oe_seen <= 1'b1;
  end

  // enable, write one status byte, then outlast the write busy time
  task automatic wr(input logic [7:0] op, input logic [7:0] v);
    cmd(1, {24'h0, WREN});
    cmd(2, {16'h0, op, v});
    repeat (8) @(posedge clk);
  endtask

  task automatic pulse_done();
    op_done <= 1'b1;
    @(posedge clk);
    op_done <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // every read byte and array event is matched against the oldest note
  always @(posedge clk) begin
    if (rx_valid === 1'b1 || op_start === 1'b1 || op_suspend === 1'b1 || op_resume === 1'b1) begin
      got = rx_valid ? {24'h0, rx_data} : op_start ? {op_code, 1'b0, op_addr} :
            op_suspend ? 32'h7500_0000 : 32'h7A00_0000;
      if (exp_q.size() == 0)
        chk(got, 32'hFFFF_FFFF);
      else
        chk(got, exp_q.pop_front());
    end
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    do_reset();
    rd(RD1, 8'h00);
    rd(RD2, 8'h00);
    rd(RD3, 8'h60);
    // drive codes with random reserved bits
    for (int i = 0; i < 4; i++) begin
      rnd_q = xs(rnd_q);
      d = (rnd_q[7:0] & 8'h9F) | (8'(i) << 5);
      wr(WR3, d);
      rd(RD3, d & 8'h64);
      chk({30'h0, strength}, 32'(i));
    end
    // latch set and clear, write refused without it
    cmd(1, {24'h0, WREN});
    rd(RD1, 8'h02);
    cmd(1, {24'h0, WRDI});
    rd(RD1, 8'h00);
    cmd(2, {16'h0, WR1, 8'h1C});
    rd(RD1, 8'h00);
    // guard against the write pin, and quad mode bypass
    wr(WR1, 8'hFF);
    rd(RD1, 8'hFC);
    wr(WR1, 8'h80);
    rd(RD1, 8'h80);
    wp_n <= 1'b0;
    wr(WR1, 8'h84);
    cmd(1, {24'h0, WRDI});
    rd(RD1, 8'h80);
    wp_n <= 1'b1;
    wr(WR2, 8'h02);
    chk({31'h0, quad_en}, 32'h1);
    wp_n <= 1'b0;
    wr(WR1, 8'h84);
    rd(RD1, 8'h84);
    wr(WR1, 8'h04);
    wr(WR2, 8'h00);
    wp_n <= 1'b1;
    // erase against each protection setting, suspend while running
    for (int i = 0; i < 10; i++) begin
      ent = tbl[i];
      wr(WR1, ent[48:41]);
      wr(WR2, ent[40:33]);
      wr(WR3, ent[32:25]);
      cmd(1, {24'h0, WREN});
      if (ent[0])
        exp_q.push_back({fscr_pkg::OP_ERASE_4K, 1'b0, ent[23:1]});
      cmd(4, {fscr_pkg::OP_ERASE_4K, ent[24:1]});
      if (ent[0]) begin
        chk({31'h0, busy}, 32'h1);
        cmd(1, {24'h0, WREN});
        exp_q.push_back(32'h7500_0000);
        cmd(1, {24'h0, fscr_pkg::OP_SUSPEND});
        chk({31'h0, busy}, 32'h0);
        rd(RD2, ent[40:33] | 8'h80);
        exp_q.push_back(32'h7A00_0000);
        cmd(1, {24'h0, fscr_pkg::OP_RESUME});
        chk({31'h0, busy}, 32'h1);
        pulse_done();
      end else begin
        cmd(1, {24'h0, WRDI});
      end
      rd(RD1, ent[48:41]);
    end
    // security lock bits are set only and lock their register
    wr(WR2, 8'h08);
    wr(WR2, 8'h00);
    rd(RD2, 8'h08);
    cmd(1, {24'h0, WREN});
    cmd(4, {fscr_pkg::OP_SECREG_ERASE, 24'h001000});
    cmd(1, {24'h0, WREN});
    exp_q.push_back({fscr_pkg::OP_SECREG_ERASE, 1'b0, 23'h002000});
    cmd(4, {fscr_pkg::OP_SECREG_ERASE, 24'h002000});
    chk({31'h0, busy}, 32'h1);
    pulse_done();
    // block erase and page program with nothing protected
    wr(WR3, 8'h60);
    cmd(1, {24'h0, WREN});
    exp_q.push_back({fscr_pkg::OP_ERASE_64K, 1'b0, 23'h010000});
    cmd(4, {fscr_pkg::OP_ERASE_64K, 24'h010000});
    pulse_done();
    cmd(1, {24'h0, WREN});
    exp_q.push_back({fscr_pkg::OP_PAGE_PROG, 1'b0, 23'h000100});
    cmd(5, {fscr_pkg::OP_PAGE_PROG, 24'h000100, 8'hA5});
    chk({31'h0, busy}, 32'h1);
    pulse_done();
    rd(RD1, 8'h00);
    // lockdown, then the prefixed permanent form, each set after a reset and refusing a status 1 write
    for (int k = 0; k < 2; k++) begin
      do_reset();
      rd(RD2, 8'h00);
      cmd(1, {24'h0, WREN});
      if (k == 1) begin
        cmd(1, {24'h0, fscr_pkg::OP_PREFIX_A});
        cmd(1, {24'h0, fscr_pkg::OP_PREFIX_B});
      end
      cmd(2, {16'h0, WR2, 8'h01});
      repeat (8) @(posedge clk);
      rd(RD2, 8'h01);
      wr(WR1, 8'h04);
      cmd(1, {24'h0, WRDI});
      rd(RD1, 8'h00);
    end
    repeat (4) @(posedge clk);
    chk(exp_q.size(), 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
